/* src/rx_flags_pkg.sv */
`default_nettype none
package rx_flags_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CABLE = 8'h6f; // Cable/decrypt levels
  localparam logic [7:0] IDX_NEWPKT = 8'h79; // New packet levels
  localparam logic [7:0] IDX_PKT_FLAGS = 8'h7e; // Packet event flags
  localparam logic [7:0] IDX_PKT_CLEAR = 8'h80; // Packet event clear
  localparam logic [7:0] IDX_CLK_FLAGS = 8'h83; // Clock event flags
  localparam logic [7:0] IDX_CLK_CLEAR = 8'h85; // Clock event clear
  localparam logic [7:0] IDX_MARKS = 8'h90; // Buffer high/low marks
  localparam logic [7:0] IDX_TOL = 8'h91; // Link freq tolerance
  localparam logic [7:0] IDX_CTS_LIM = 8'h92; // CTS change limit
  localparam logic [7:0] IDX_IRQ_STAT = 8'h93; // Interrupt status
  localparam logic [7:0] IDX_IRQ_MASK = 8'h94; // Interrupt mask
  localparam int ADR_W = 10; // Byte address width
  // Bit positions in the packet event bank
  localparam int B_GAMUT = 0;
  localparam int B_BODY_ERR = 1;
  localparam int B_PKT_ERR = 2;
  localparam int B_N_CHG = 3;
  localparam int B_CTS = 4;
  localparam int B_OVERRUN = 5;
  localparam int B_UNDERRUN = 6;
  localparam int B_NEAR_FULL = 7;
  // Bit positions in the clock event bank
  localparam int B_NEAR_EMPTY = 0;
  localparam int B_FREQ = 1;
  localparam int B_FLAT = 2;
  localparam int B_RATE = 3;
  localparam int B_PARITY = 4;
  localparam int B_TYPE = 5;
  localparam int B_IRREG = 6;
  localparam int B_DEPTH = 7;
  // Field positions in the marks register
  localparam int F_HIGH_LSB = 0;
  localparam int F_LOW_LSB = 8;
  // Reset values of control registers
  localparam logic [7:0] RST_HIGH_MARK = 8'h60;
  localparam logic [7:0] RST_LOW_MARK = 8'h20;
  localparam logic [3:0] RST_TOL = 4'h4;
  localparam logic [19:0] RST_CTS_LIM = 20'h00100;
  localparam logic [15:0] RST_IRQ_MASK = 16'h0000;
  // Both event banks travel together
  typedef struct packed {
    logic [7:0] clk; // Clock bank, upper byte
    logic [7:0] pkt; // Packet bank, lower byte
  } flag_bank_t;
  // Received audio kind
  typedef enum logic [2:0] {
    AUD_NONE, AUD_PCM, AUD_DSD, AUD_HBR, AUD_DST
  } audio_kind_t;
endpackage
`default_nettype wire

/* src/rx_packet_audio_status_flags.sv */
// Overview of operation
// R1: Changed gamut packet sets flag until cleared
// R2: Audio body uncorrectable error sets sticky flag
// R3: Any packet correction failure sets sticky flag
// R4: Changed regeneration N value sets sticky flag
// R5: CTS moving beyond limit sets sticky flag
// R6: Write pointer reaching read pointer flags overrun
// R7: Read pointer reaching write pointer flags underrun
// R8: Stereo entry count at/above high mark
// R9: Stereo entry count at/below low mark
// R10: Link frequency shift beyond tolerance sets flag
// R11: Sample packet with flat bit sets flag
// R12: Sampling frequency field change sets flag
// R13: Audio sample parity error sets flag
// R14: Audio kind change among five kinds
// R15: Irregular or missing link clock pulses
// R16: Deep colour mode change sets flag
// R17: Writing one clears; zero ignored; reads zero
// R18: Set wins over same-cycle clear
`timescale 1ns/1ps
`default_nettype none
module rx_packet_audio_status_flags #(
  parameter int PTR_W = 7, // Audio buffer pointer width
  parameter int FREQ_W = 13 // Measured link frequency width
) (
  input wire logic MCLK_I, // 200 MHz clock
  input wire logic RESETN_I, // Async reset, active low
  // Classic Wishbone slave
  input wire logic CYC_I, // Bus cycle
  input wire logic STB_I, // Strobe
  input wire logic WE_I, // Write enable
  input wire logic [3:0] SEL_I, // Byte lanes
  input wire logic [rx_flags_pkg::ADR_W-1:0] ADR_I, // Byte address
  input wire logic [31:0] DAT_I, // Write data
  output logic [31:0] DAT_O, // Read data
  output logic ACK_O, // Acknowledge
  output logic IRQ_O, // Level interrupt
  // Read-only level groups
  input wire logic [2:0] CABLE_FLAGS_I, // Cable/decrypt levels
  input wire logic [7:0] NEW_PKT_FLAGS_I, // New packet levels
  // Packet processing events
  input wire logic GAMUT_STB_I, // Gamut packet received
  input wire logic [31:0] GAMUT_SUM_I, // Gamut content digest
  input wire logic BODY_ERR_I, // Audio body uncorrectable
  input wire logic PKT_ERR_I, // Any packet uncorrectable
  input wire logic ACR_STB_I, // Regeneration packet
  input wire logic [19:0] ACR_N_I, // N value
  input wire logic [19:0] ACR_CTS_I, // CTS value
  // Audio buffer pointers
  input wire logic BUF_WR_I, // Buffer write
  input wire logic BUF_RD_I, // Buffer read
  input wire logic [PTR_W-1:0] WR_PTR_I, // Write pointer
  input wire logic [PTR_W-1:0] RD_PTR_I, // Read pointer
  // Audio sample events
  input wire logic SAMPLE_STB_I, // Sample packet received
  input wire logic FLAT_BIT_I, // Flat line bit
  input wire logic PARITY_ERR_I, // Sample parity error
  input wire logic CS_STB_I, // Channel status valid
  input wire logic [3:0] FS_FIELD_I, // Sampling freq field
  input wire logic PCM_AUDIO_SEEN_I, // PCM detected
  input wire logic ONE_BIT_AUDIO_SEEN_I, // One-bit detected
  input wire logic COMPRESSED_ONE_BIT_SEEN_I, // Compressed one-bit
  input wire logic HIGH_RATE_AUDIO_SEEN_I, // High rate detected
  // Link monitoring
  input wire logic FREQ_STB_I, // New frequency measure
  input wire logic [FREQ_W-1:0] FREQ_I, // Measured frequency
  input wire logic CLK_IRREG_I, // Irregular link clock
  input wire logic [1:0] DEPTH_MODE_I, // Deep colour mode
  output logic [15:0] FLAGS_O // Raw flags, both banks
);

  // Absolute difference, shared by the CTS and frequency checks
  function automatic logic [19:0] abs_diff(
    input logic [19:0] a,
    input logic [19:0] b
  );
    // Larger minus smaller, so no wrap on an unsigned result
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

  // Byte-lane merge of write data into a register image
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    // Lanes with a clear select keep the old byte
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // Bus decode
  logic req; // Request pending, not yet answered
  logic acc; // Edge at which the access completes
  logic [7:0] idx; // Register index
  logic adr_ok; // Address word aligned, any index
  logic wr; // Write completes this edge
  logic rd; // Read completes this edge

  // ACK_O masks the request, so a held strobe is answered every other cycle
  assign req = CYC_I & STB_I & ~ACK_O;
  assign acc = CYC_I & STB_I & ACK_O;
  assign idx = ADR_I[9:2];
  // Misaligned addresses are acknowledged but touch nothing
  assign adr_ok = (ADR_I[1:0] == 2'h0);
  assign wr = acc & WE_I & adr_ok;
  assign rd = acc & ~WE_I & adr_ok;

  // Control registers
  logic [7:0] audio_buf_high_mark; // Near-full mark
  logic [7:0] low_mark; // audio_buf_low_mark
  logic [3:0] link_freq_tolerance; // Allowed frequency shift
  logic [19:0] cts_limit; // Allowed CTS movement
  logic [15:0] irq_mask; // Interrupt mask, flag layout
  logic [15:0] irq_stat; // Sticky interrupt status
  rx_flags_pkg::flag_bank_t flags; // Raw sticky flags
  rx_flags_pkg::flag_bank_t set_ev; // Events this cycle
  rx_flags_pkg::flag_bank_t clr; // Clear strobes this cycle
  logic [31:0] marks_img; // Marks register image
  logic [31:0] marks_new; // Marks after merge

  assign marks_img = {16'h0000, low_mark, audio_buf_high_mark};
  assign marks_new = merge(marks_img, DAT_I, SEL_I);

  // Control writes, taken at the acknowledge edge
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      audio_buf_high_mark <= rx_flags_pkg::RST_HIGH_MARK;
      low_mark <= rx_flags_pkg::RST_LOW_MARK;
      link_freq_tolerance <= rx_flags_pkg::RST_TOL;
      cts_limit <= rx_flags_pkg::RST_CTS_LIM;
      irq_mask <= rx_flags_pkg::RST_IRQ_MASK;
    end else if (wr) begin
      case (idx)
        rx_flags_pkg::IDX_MARKS: begin
          // Unselected lanes keep their old byte
          audio_buf_high_mark <= marks_new[rx_flags_pkg::F_HIGH_LSB +: 8];
          low_mark <= marks_new[rx_flags_pkg::F_LOW_LSB +: 8];
        end
        rx_flags_pkg::IDX_TOL: begin
          // Only lane 0 carries the tolerance
          if (SEL_I[0]) begin
            link_freq_tolerance <= DAT_I[3:0];
          end
        end
        rx_flags_pkg::IDX_CTS_LIM: begin
          // Bits above the limit's width are dropped on purpose
          cts_limit <= 20'(merge({12'h000, cts_limit}, DAT_I, SEL_I));
        end
        rx_flags_pkg::IDX_IRQ_MASK: begin
          irq_mask <= 16'(merge({16'h0000, irq_mask}, DAT_I, SEL_I));
        end
        default: begin
          // Other indices hold no control state
        end
      endcase
    end
  end

  // Clear strobes; only a one in lane 0 clears, zeros do nothing
  // Clear registers hold nothing, the strobe lasts one cycle
  always_comb begin
    clr = '0;
    if (wr && SEL_I[0]) begin
      if (idx == rx_flags_pkg::IDX_PKT_CLEAR) begin
        clr.pkt = DAT_I[7:0]; // R17
      end
      if (idx == rx_flags_pkg::IDX_CLK_CLEAR) begin
        clr.clk = DAT_I[7:0]; // R17
      end
    end
  end

  // History of previously received values
  logic [31:0] gamut_prev; // Last gamut digest
  logic gamut_seen; // A gamut packet was received
  logic [19:0] n_prev; // Last regeneration N
  logic [19:0] cts_prev; // Last regeneration CTS
  logic acr_seen; // A regeneration packet was received
  logic [3:0] fs_prev; // Last sampling freq field
  logic cs_seen; // Channel status was received
  logic [FREQ_W-1:0] freq_ref; // Reference link frequency
  logic freq_seen; // A measurement was taken
  logic freq_moved; // Shift beyond tolerance
  rx_flags_pkg::audio_kind_t kind; // Current audio kind
  rx_flags_pkg::audio_kind_t kind_prev; // Previous audio kind
  logic [1:0] depth_prev; // Previous deep colour mode

  // First packet only primes the history, it is not a change
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      gamut_prev <= 32'h0000_0000;
      gamut_seen <= 1'b0;
      n_prev <= 20'h00000;
      cts_prev <= 20'h00000;
      acr_seen <= 1'b0;
      fs_prev <= 4'h0;
      cs_seen <= 1'b0;
      freq_ref <= '0;
      freq_seen <= 1'b0;
    end else begin
      // Digest compare only; a collision would hide a change
      if (GAMUT_STB_I) begin
        gamut_prev <= GAMUT_SUM_I;
        gamut_seen <= 1'b1;
      end
      // N and CTS history both advance on every packet
      if (ACR_STB_I) begin
        n_prev <= ACR_N_I;
        cts_prev <= ACR_CTS_I;
        acr_seen <= 1'b1;
      end
      // Whole field compared, any bit change counts
      if (CS_STB_I) begin
        fs_prev <= FS_FIELD_I;
        cs_seen <= 1'b1;
      end
      // Reference moves only on a reported shift, so slow drift
      // accumulates until it crosses the tolerance
      if (FREQ_STB_I && (!freq_seen || freq_moved)) begin
        freq_ref <= FREQ_I;
        freq_seen <= 1'b1;
      end
    end
  end

  // Audio kind and colour depth history, updated every cycle
  // A glitch on a detector line shows as two changes
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      kind_prev <= rx_flags_pkg::AUD_NONE;
      depth_prev <= 2'h0;
    end else begin
      kind_prev <= kind;
      depth_prev <= DEPTH_MODE_I;
    end
  end

  // Audio kind from the detection bits; one-bit kinds first
  // Several detectors high at once count as the first one
  always_comb begin
    if (COMPRESSED_ONE_BIT_SEEN_I) begin
      kind = rx_flags_pkg::AUD_DST;
    end else if (ONE_BIT_AUDIO_SEEN_I) begin
      kind = rx_flags_pkg::AUD_DSD;
    end else if (HIGH_RATE_AUDIO_SEEN_I) begin
      kind = rx_flags_pkg::AUD_HBR;
    end else if (PCM_AUDIO_SEEN_I) begin
      kind = rx_flags_pkg::AUD_PCM;
    end else begin
      kind = rx_flags_pkg::AUD_NONE;
    end
  end

  // Event detectors
  logic [19:0] freq_delta; // Frequency shift
  logic [19:0] cts_delta; // CTS movement
  logic [PTR_W-1:0] wr_next; // Write pointer after write
  logic [PTR_W-1:0] fill; // Entries holding stereo data

  assign freq_delta = abs_diff(20'(FREQ_I), 20'(freq_ref));
  assign freq_moved = (freq_delta > 20'(link_freq_tolerance));
  assign cts_delta = abs_diff(ACR_CTS_I, cts_prev);
  // Overrun looks one write ahead of the read pointer
  assign wr_next = WR_PTR_I + PTR_W'(1);
  // Fill wraps with the pointers, so a full buffer reads as
  // empty; the overrun flag is what reports that case
  assign fill = WR_PTR_I - RD_PTR_I;

  // Level sources set their flag on every cycle they hold
  always_comb begin
    set_ev = '0;
    set_ev.pkt[rx_flags_pkg::B_GAMUT] = GAMUT_STB_I & gamut_seen &
      (GAMUT_SUM_I != gamut_prev); // R1
    set_ev.pkt[rx_flags_pkg::B_BODY_ERR] = BODY_ERR_I; // R2
    set_ev.pkt[rx_flags_pkg::B_PKT_ERR] = PKT_ERR_I; // R3
    set_ev.pkt[rx_flags_pkg::B_N_CHG] = ACR_STB_I & acr_seen &
      (ACR_N_I != n_prev); // R4
    set_ev.pkt[rx_flags_pkg::B_CTS] = ACR_STB_I & acr_seen &
      (cts_delta > cts_limit); // R5
    set_ev.pkt[rx_flags_pkg::B_OVERRUN] = BUF_WR_I &
      (wr_next == RD_PTR_I); // R6
    set_ev.pkt[rx_flags_pkg::B_UNDERRUN] = BUF_RD_I &
      (RD_PTR_I == WR_PTR_I); // R7
    set_ev.pkt[rx_flags_pkg::B_NEAR_FULL] =
      (32'(fill) >= 32'(audio_buf_high_mark)); // R8
    set_ev.clk[rx_flags_pkg::B_NEAR_EMPTY] =
      (32'(fill) <= 32'(low_mark)); // R9
    set_ev.clk[rx_flags_pkg::B_FREQ] = FREQ_STB_I & freq_seen &
      freq_moved; // R10
    set_ev.clk[rx_flags_pkg::B_FLAT] = SAMPLE_STB_I & FLAT_BIT_I; // R11
    set_ev.clk[rx_flags_pkg::B_RATE] = CS_STB_I & cs_seen &
      (FS_FIELD_I != fs_prev); // R12
    set_ev.clk[rx_flags_pkg::B_PARITY] = SAMPLE_STB_I &
      PARITY_ERR_I; // R13
    set_ev.clk[rx_flags_pkg::B_TYPE] = (kind != kind_prev); // R14
    set_ev.clk[rx_flags_pkg::B_IRREG] = CLK_IRREG_I; // R15
    set_ev.clk[rx_flags_pkg::B_DEPTH] =
      (DEPTH_MODE_I != depth_prev); // R16
  end

  // Sticky raw flags; an event in the clearing cycle survives
  // A level-held flag clears for good only once its cause ends
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flags <= '0;
    end else begin
      flags <= set_ev | (flags & ~clr); // R18
    end
  end

  // Interrupt status: set by events, cleared by reading it
  // Writes to the clear registers leave this copy untouched
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_stat <= 16'h0000;
    end else if (rd && idx == rx_flags_pkg::IDX_IRQ_STAT) begin
      irq_stat <= set_ev; // Event in the reading cycle is kept
    end else begin
      irq_stat <= irq_stat | set_ev;
    end
  end

  // Level interrupt while any unmasked status bit is set
  // Registered for a clean pin, at one cycle of extra latency
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat & irq_mask);
    end
  end

  // Raw flags leave the block straight from the register
  assign FLAGS_O = flags;

  // Read mux; clear registers and unmapped words read as zero
  // Level groups are shown as they stand, not latched
  logic [31:0] rdata; // Selected read word

  always_comb begin
    rdata = 32'h0000_0000;
    if (adr_ok) begin
      case (idx)
        rx_flags_pkg::IDX_CABLE: rdata[2:0] = CABLE_FLAGS_I;
        rx_flags_pkg::IDX_NEWPKT: rdata[7:0] = NEW_PKT_FLAGS_I;
        rx_flags_pkg::IDX_PKT_FLAGS: rdata[7:0] = flags.pkt;
        rx_flags_pkg::IDX_CLK_FLAGS: rdata[7:0] = flags.clk;
        rx_flags_pkg::IDX_MARKS: rdata = marks_img;
        rx_flags_pkg::IDX_TOL: rdata[3:0] = link_freq_tolerance;
        rx_flags_pkg::IDX_CTS_LIM: rdata[19:0] = cts_limit;
        rx_flags_pkg::IDX_IRQ_STAT: rdata[15:0] = irq_stat;
        rx_flags_pkg::IDX_IRQ_MASK: rdata[15:0] = irq_mask;
        default: rdata = 32'h0000_0000; // Clear regs read zero
      endcase
    end
  end

  // One wait state: answer one edge after the request, for one cycle
  // DAT_O keeps the last read word; writes leave it alone
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= req;
      if (req && !WE_I) begin
        DAT_O <= rdata;
      end
    end
  end

endmodule
`default_nettype wire

/* testbench/rx_flags_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus timing, flag setting and packet flag clearing seen at the top ports only
module rx_flags_checker #(
  parameter int PTR_W = 7, // Pointer width
  parameter int FREQ_W = 13 // Frequency width
) (
  input wire logic MCLK_I, // Clock
  input wire logic RESETN_I, // Reset, active low
  input wire logic CYC_I, // Bus cycle
  input wire logic STB_I, // Strobe
  input wire logic WE_I, // Write enable
  input wire logic [3:0] SEL_I, // Lanes
  input wire logic [rx_flags_pkg::ADR_W-1:0] ADR_I, // Address
  input wire logic [31:0] DAT_I, // Write data
  input wire logic ACK_O, // Acknowledge
  input wire logic BODY_ERR_I, // Body error
  input wire logic PKT_ERR_I, // Packet error
  input wire logic SAMPLE_STB_I, // Sample packet
  input wire logic FLAT_BIT_I, // Flat bit
  input wire logic PARITY_ERR_I, // Parity error
  input wire logic CLK_IRREG_I, // Irregular clock
  input wire logic [15:0] FLAGS_O // Raw flags
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  // One wait state, then a single-cycle acknowledge
  a_ack_after_req: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  // Events land in the bank one edge later, also against a clear
  a_body_err_set: assert property (BODY_ERR_I |=> FLAGS_O[1])
    else $error("body error flag not set");
  a_pkt_err_set: assert property (PKT_ERR_I |=> FLAGS_O[2])
    else $error("packet error flag not set");
  a_flat_set: assert property (SAMPLE_STB_I && FLAT_BIT_I
    |=> FLAGS_O[10])
    else $error("flat line flag not set");
  a_parity_set: assert property (SAMPLE_STB_I && PARITY_ERR_I
    |=> FLAGS_O[12])
    else $error("parity flag not set");
  a_irreg_set: assert property (CLK_IRREG_I |=> FLAGS_O[14])
    else $error("irregular clock flag not set");
  // A packet flag falls only under a one in an acked clear write
  a_pkt_clear_only: assert property (
    |($past(FLAGS_O[7:0]) & ~FLAGS_O[7:0])
    |-> $past(ACK_O && WE_I && SEL_I[0] && ADR_I == 10'h200)
    && (($past(FLAGS_O[7:0]) & ~FLAGS_O[7:0] & ~$past(DAT_I[7:0])) == 8'h00))
    else $error("packet flag fell without clear");
endmodule
bind rx_packet_audio_status_flags rx_flags_checker #(.PTR_W(PTR_W),
  .FREQ_W(FREQ_W)) chk (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .SEL_I(SEL_I), .ADR_I(ADR_I),
  .DAT_I(DAT_I), .ACK_O(ACK_O), .BODY_ERR_I(BODY_ERR_I),
  .PKT_ERR_I(PKT_ERR_I), .SAMPLE_STB_I(SAMPLE_STB_I),
  .FLAT_BIT_I(FLAT_BIT_I), .PARITY_ERR_I(PARITY_ERR_I),
  .CLK_IRREG_I(CLK_IRREG_I), .FLAGS_O(FLAGS_O));
`default_nettype wire

/* testbench/rx_flags_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host software as a classic bus master
module rx_flags_host (
  input wire logic clk_i, // Bus clock
  input wire logic ack_i, // Slave acknowledge
  output logic cyc_o, // Cycle
  output logic stb_o, // Strobe
  output logic we_o, // Write enable
  output logic [3:0] sel_o, // Lanes
  output logic [9:0] adr_o, // Byte address
  output logic [31:0] dat_o // Write data
);
  // Idle bus from time zero
  initial begin
    {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
  end
  // Request held until ack is seen; released lines show inverted data
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
    {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'b11, w, 4'hf, a, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    {cyc_o, stb_o, adr_o, dat_o} <= {2'b00, ~a, ~d};
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* testbench/rx_packet_audio_status_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_packet_audio_status_flags_tb_top;
  typedef struct packed {
    logic care; // Compare this read
    logic [9:0] adr; // Address read
    logic [31:0] exp; // Expected word
  } note_t;
  note_t notes[$]; // Pending reads, oldest first
  note_t nt; // Note being compared
  int n_errors = 0, checked = 0, cycles = 0, seed = 19;
  int seq[$] = {0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15,
                13, 13, 13, 13}; // Repeats walk all audio kinds
  logic clk = 0, rst_n = 0, cyc, stb, we, ack, irq;
  logic [3:0] sel, kind = 4'h0, fs = 4'h0; // Kind detectors, fs field
  logic [9:0] adr;
  logic [31:0] wdat, rdat, gsum = 32'h0;
  logic [15:0] flags, exp;
  logic [2:0] cable = 3'h0;
  logic [7:0] newpkt = 8'h0;
  logic gstb = 0, body = 0, perr = 0, acr = 0, bwr = 0, brd = 0, sstb = 0;
  logic flat = 0, par = 0, cs = 0, fstb = 0, irreg = 0;
  logic [19:0] n_val = 20'h01800, cts = 20'h01000;
  logic [6:0] wptr = 7'h40, rptr = 7'h00; // Fill between the marks
  logic [12:0] freq = 13'h1000;
  logic [1:0] depth = 2'h0;
  // Free-running 200 MHz clock
  initial forever #2.5 clk = ~clk;
  rx_packet_audio_status_flags #(.PTR_W(7), .FREQ_W(13)) DUT (
    .MCLK_I(clk), .RESETN_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .SEL_I(sel), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .IRQ_O(irq), .CABLE_FLAGS_I(cable), .NEW_PKT_FLAGS_I(newpkt),
    .GAMUT_STB_I(gstb), .GAMUT_SUM_I(gsum), .BODY_ERR_I(body),
    .PKT_ERR_I(perr), .ACR_STB_I(acr), .ACR_N_I(n_val), .ACR_CTS_I(cts),
    .BUF_WR_I(bwr), .BUF_RD_I(brd), .WR_PTR_I(wptr), .RD_PTR_I(rptr),
    .SAMPLE_STB_I(sstb), .FLAT_BIT_I(flat), .PARITY_ERR_I(par),
    .CS_STB_I(cs), .FS_FIELD_I(fs), .PCM_AUDIO_SEEN_I(kind[0]),
    .ONE_BIT_AUDIO_SEEN_I(kind[1]), .COMPRESSED_ONE_BIT_SEEN_I(kind[2]),
    .HIGH_RATE_AUDIO_SEEN_I(kind[3]), .FREQ_STB_I(fstb), .FREQ_I(freq),
    .CLK_IRREG_I(irreg), .DEPTH_MODE_I(depth), .FLAGS_O(flags));
  rx_flags_host host (.clk_i(clk), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));
  task automatic check(input string what, input logic [31:0] seen, e);
    checked++;
    if (seen !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [9:0] at(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, logic c);
    notes.push_back({c, at(idx), e});
    host.xfer(1'b0, at(idx), 32'h0);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    host.xfer(1'b1, at(idx), d);
  endtask
  // One event of kind k for one cycle, then pointers back mid-buffer
  task automatic fire(input int k);
    case (k)
      0: gsum <= ~gsum;
      3: n_val <= n_val + 20'h1;
      4: cts <= cts + 20'h00101;
      5: wptr <= rptr - 7'h1;
      6: rptr <= wptr;
      7: wptr <= 7'h60;
      8: wptr <= 7'h20;
      9: freq <= freq + 13'h5;
      11: fs <= fs + 4'h1;
      13: kind <= (kind == 4'h0) ? 4'h1 : {kind[2:0], 1'b0};
      15: depth <= depth + 2'h1;
      default: ;
    endcase
    {gstb, body, perr, acr, bwr, brd} <= {k == 0, k == 1, k == 2,
      k == 3 || k == 4, k == 5, k == 6};
    {fstb, sstb, flat, cs, par, irreg} <= {k == 9, k == 10 || k == 12,
      k == 10, k == 11, k == 12, k == 14};
    @(posedge clk);
    {gstb, body, perr, acr, bwr, brd, fstb, sstb, flat, cs, par} <= '0;
    {irreg, wptr, rptr} <= {1'b0, 7'h40, 7'h00};
    repeat (2) @(posedge clk);
  endtask
  // Read words compared with the oldest note; hang guard
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
      nt = notes.pop_front();
      if (nt.care) check($sformatf("read %h", nt.adr), rdat, nt.exp);
    end
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    {gsum, cable, newpkt} <= {$random(seed), 3'($random(seed)), 8'h5a};
    {gstb, acr, cs, fstb} <= 4'hf; // Histories primed, no flag yet
    @(posedge clk);
    {gstb, acr, cs, fstb} <= 4'h0;
    wr(rx_flags_pkg::IDX_PKT_CLEAR, 32'hff);
    wr(rx_flags_pkg::IDX_CLK_CLEAR, 32'hff);
    rd(rx_flags_pkg::IDX_PKT_FLAGS, 32'h0, 1'b1);
    rd(rx_flags_pkg::IDX_MARKS, {rx_flags_pkg::RST_LOW_MARK,
       rx_flags_pkg::RST_HIGH_MARK}, 1'b1);
    rd(rx_flags_pkg::IDX_TOL, rx_flags_pkg::RST_TOL, 1'b1);
    rd(rx_flags_pkg::IDX_CTS_LIM, rx_flags_pkg::RST_CTS_LIM, 1'b1);
    rd(rx_flags_pkg::IDX_IRQ_MASK, rx_flags_pkg::RST_IRQ_MASK, 1'b1);
    rd(rx_flags_pkg::IDX_CABLE, cable, 1'b1);
    rd(rx_flags_pkg::IDX_NEWPKT, newpkt, 1'b1);
    rd(8'hff, 32'h0, 1'b1);
    rd(rx_flags_pkg::IDX_PKT_CLEAR, 32'h0, 1'b1);
    rd(rx_flags_pkg::IDX_CLK_CLEAR, 32'h0, 1'b1);
    // Every event: zero write keeps it, one write clears it
    foreach (seq[i]) begin
      fire(seq[i]);
      exp = (16'h1 << seq[i]) | (seq[i] == 5 ? 16'h80 : 16'h0)
          | (seq[i] == 6 ? 16'h100 : 16'h0);
      wr(rx_flags_pkg::IDX_PKT_CLEAR, 32'h0);
      wr(rx_flags_pkg::IDX_CLK_CLEAR, 32'h0);
      rd(rx_flags_pkg::IDX_PKT_FLAGS, exp[7:0], 1'b1);
      rd(rx_flags_pkg::IDX_CLK_FLAGS, exp[15:8], 1'b1);
      check("flags", flags, exp);
      wr(rx_flags_pkg::IDX_PKT_CLEAR, 32'hff);
      wr(rx_flags_pkg::IDX_CLK_CLEAR, 32'hff);
      rd(rx_flags_pkg::IDX_PKT_FLAGS, 32'h0, 1'b1);
      rd(rx_flags_pkg::IDX_CLK_FLAGS, 32'h0, 1'b1);
    end
    // Interrupt masked, then unmasked, then cleared by the read
    rd(rx_flags_pkg::IDX_IRQ_STAT, 32'h0, 1'b0);
    fire(1);
    check("irq masked", irq, 32'h0);
    rd(rx_flags_pkg::IDX_IRQ_STAT, 32'h2, 1'b1);
    wr(rx_flags_pkg::IDX_IRQ_MASK, 32'h2);
    fire(1);
    check("irq", irq, 32'h1);
    rd(rx_flags_pkg::IDX_IRQ_STAT, 32'h2, 1'b1);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 32'h0);
    // Event in the cycle the clear lands
    fork
      wr(rx_flags_pkg::IDX_PKT_CLEAR, 32'hff);
      begin
        @(posedge clk);
        body <= 1'b1;
        @(posedge clk);
        body <= 1'b0;
      end
    join
    rd(rx_flags_pkg::IDX_PKT_FLAGS, 32'h2, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
